// File: design/cmpctl_axil.sv
/*
 * AXI4-Lite slave front end; turns bus transfers into register strobes.
 * Assumes byte address = 4 x register index, data in the low byte lane.
 */
`timescale 1ns/1ps
module cmpctl_axil
	import cmpctl_pkg::*;
(
	// clock and reset
	input  wire logic                  clk_i,
	input  wire logic                  rstn_i,
	input  wire logic                  ce_i,
	// write channels
	input  wire logic [AXI_ADDR_W-1:0] awaddr_i,
	input  wire logic                  awvalid_i,
	output logic                       awready_o,
	input  wire logic [AXI_DATA_W-1:0] wdata_i,
	input  wire logic [3:0]            wstrb_i,
	input  wire logic                  wvalid_i,
	output logic                       wready_o,
	output logic [1:0]                 bresp_o,
	output logic                       bvalid_o,
	input  wire logic                  bready_i,
	// read channels
	input  wire logic [AXI_ADDR_W-1:0] araddr_i,
	input  wire logic                  arvalid_i,
	output logic                       arready_o,
	output logic [AXI_DATA_W-1:0]      rdata_o,
	output logic [1:0]                 rresp_o,
	output logic                       rvalid_o,
	input  wire logic                  rready_i,
	// register side
	cmpctl_reg_if.bus                  rif
);
	logic             aw_held_r;
	logic             w_held_r;
	logic [IDX_W-1:0] aw_idx_r;
	logic [REG_W-1:0] wdata_r;
	logic             lane0_r;
	logic             do_wr;

	assign awready_o = ce_i && !aw_held_r && !bvalid_o;
	assign wready_o  = ce_i && !w_held_r && !bvalid_o;
	assign arready_o = ce_i && !rvalid_o;
	assign do_wr     = ce_i && aw_held_r && w_held_r && !bvalid_o;

	// a write without lane 0 is answered but stores nothing
	assign rif.wr_stb  = do_wr && lane0_r;
	assign rif.wr_idx  = aw_idx_r;
	assign rif.wr_data = wdata_r;
	assign rif.rd_stb  = arvalid_i && arready_o;
	assign rif.rd_idx  = araddr_i[AXI_ADDR_W-1:2];

	always_ff @(posedge clk_i or negedge rstn_i)
	begin
		if (!rstn_i)
		begin
			aw_held_r <= 1'b0;
			w_held_r  <= 1'b0;
			aw_idx_r  <= '0;
			wdata_r   <= '0;
			lane0_r   <= 1'b0;
			bvalid_o  <= 1'b0;
			bresp_o   <= RESP_OKAY;
		end
		else if (ce_i)
		begin
			if (awvalid_i && awready_o)
			begin
				aw_held_r <= 1'b1;
				aw_idx_r  <= awaddr_i[AXI_ADDR_W-1:2];
			end
			if (wvalid_i && wready_o)
			begin
				w_held_r <= 1'b1;
				wdata_r  <= wdata_i[REG_W-1:0];
				lane0_r  <= wstrb_i[0];
			end
			if (do_wr)
			begin
				aw_held_r <= 1'b0;
				w_held_r  <= 1'b0;
				bvalid_o  <= 1'b1;
				bresp_o   <= rif.wr_ok ? RESP_OKAY : RESP_SLVERR;
			end
			else if (bvalid_o && bready_i)
				bvalid_o <= 1'b0;
		end
	end

	always_ff @(posedge clk_i or negedge rstn_i)
	begin
		if (!rstn_i)
		begin
			rvalid_o <= 1'b0;
			rdata_o  <= '0;
			rresp_o  <= RESP_OKAY;
		end
		else if (ce_i)
		begin
			if (rif.rd_stb)
			begin
				rvalid_o <= 1'b1;
				rdata_o  <= {{(AXI_DATA_W-REG_W){1'b0}}, rif.rd_data};
				rresp_o  <= rif.rd_ok ? RESP_OKAY : RESP_SLVERR;
			end
			else if (rvalid_o && rready_i)
				rvalid_o <= 1'b0;
		end
	end
endmodule // cmpctl_axil

// File: design/cmpctl_sync.sv
/*
 * Two-stage synchroniser for a single level.
 * Assumes the input may change at any time relative to the clock.
 */
`timescale 1ns/1ps
module cmpctl_sync (
	// clock and reset
	input  wire logic clk_i,
	input  wire logic rstn_i,
	input  wire logic ce_i,
	// level
	input  wire logic d_i,
	output logic      q_o
);
	logic meta_r;

	always_ff @(posedge clk_i or negedge rstn_i)
	begin
		if (!rstn_i)
		begin
			meta_r <= 1'b0;
			q_o    <= 1'b0;
		end
		else if (ce_i)
		begin
			meta_r <= d_i;
			q_o    <= meta_r;
		end
	end
endmodule // cmpctl_sync

// File: design/cmpctl_top.sv
/*
 * Comparator control core: mode routing, reference level, output pin,
 * change flag and interrupt request, registers behind AXI4-Lite.
 * Assumes analog levels arrive as codes in 96ths of the supply, and the
 * digital pin levels are synchronous to the core clock.
 */
`timescale 1ns/1ps
// Behaviour
// R1: raw result high when positive input exceeds negative
// R2: invert bit complements the reported output
// R3: output status bit read only
// R4: three-bit field selects eight modes
// R5: software masks interrupt during mode change
// R6: three modes drive pin unsynchronised
// R7: direction bit enables output driver
// R8: analog pins read zero in port data
// R9: four modes use internal reference
// R10: 32 reference settings, two ranges
// R11: range bit one selects low range
// R12: enable bit powers reference circuit
// R13: enabled circuits keep running in sleep
// R14: software turns everything off before sleep
// R15: interrupt wakes device; registers kept
// R16: reset gives mode zero, reference off
// R17: flag sets when output changes
// R18: write zero clears, one sets flag
// R19: request needs all three enables
// R20: control register access latches output
// R21: change during access may be missed
// R22: reference bits six, four read zero
// R23: input switch picks negative input source
// R24: result synchronised before status logic
module cmpctl_top
	import cmpctl_pkg::*;
#(
	parameter int CODE_W = 7
) (
	// clock, reset, enable
	input  wire logic                           CORE_CLK_I,
	input  wire logic                           RSTN_I,
	input  wire logic                           CE_I,
	// axi4-lite write
	input  wire logic [cmpctl_pkg::AXI_ADDR_W-1:0] S_AXI_AWADDR_I,
	input  wire logic                           S_AXI_AWVALID_I,
	output logic                                S_AXI_AWREADY_O,
	input  wire logic [cmpctl_pkg::AXI_DATA_W-1:0] S_AXI_WDATA_I,
	input  wire logic [3:0]                     S_AXI_WSTRB_I,
	input  wire logic                           S_AXI_WVALID_I,
	output logic                                S_AXI_WREADY_O,
	output logic [1:0]                          S_AXI_BRESP_O,
	output logic                                S_AXI_BVALID_O,
	input  wire logic                           S_AXI_BREADY_I,
	// axi4-lite read
	input  wire logic [cmpctl_pkg::AXI_ADDR_W-1:0] S_AXI_ARADDR_I,
	input  wire logic                           S_AXI_ARVALID_I,
	output logic                                S_AXI_ARREADY_O,
	output logic [cmpctl_pkg::AXI_DATA_W-1:0]   S_AXI_RDATA_O,
	output logic [1:0]                          S_AXI_RRESP_O,
	output logic                                S_AXI_RVALID_O,
	input  wire logic                           S_AXI_RREADY_I,
	// analog front end
	input  wire logic [CODE_W-1:0]              POS_PIN_CODE_I,
	input  wire logic [CODE_W-1:0]              NEG_PIN_CODE_I,
	output logic [CODE_W-1:0]                   REF_CODE_O,
	output logic                                REF_POWER_O,
	output logic                                CMP_POWER_O,
	// pins
	input  wire logic [cmpctl_pkg::PIN_N-1:0]   PIN_I,
	output logic                                CMP_PIN_O,
	output logic                                CMP_PIN_OE_O,
	// system
	input  wire logic                           SLEEP_I,
	output logic                                IRQ_O,
	output logic                                WAKE_O
);
	import cmpctl_pkg::*;

	if (CODE_W < 7)
	begin : g_bad_code_w
		$error("CODE_W must hold the full-scale reference code");
	end

	cmpctl_reg_if rif ();

	// register state
	logic [REG_W-1:0]  core_irq_r;
	logic              change_flag_r;
	logic              output_invert_r;
	logic              input_switch_r;
	cmpctl_mode_t      mode_r;
	logic [PIN_N-1:0]  pin_direction_r;
	logic              change_enable_r;
	logic              ref_enable_r;
	logic              ref_range_r;
	logic [LVL_W-1:0]  ref_level_r;
	logic              latched_out_r;
	logic              change_flag_nxt;

	// datapath
	logic              cmp_on;
	logic              uses_ref;
	logic              drives_pin;
	logic              uses_pos_pin;
	logic [6:0]        ref_code;
	logic [CODE_W-1:0] positive_input;
	logic [CODE_W-1:0] negative_input;
	logic              raw_result;
	logic              shown_result;
	logic              compare_result;
	logic [PIN_N-1:0]  analog_pin;
	logic [PIN_N-1:0]  port_data;
	logic              ctl_access;
	logic              mismatch;
	logic              wr_core;
	logic              wr_flags;
	logic              wr_cmp;
	logic              wr_dir;
	logic              wr_en;
	logic              wr_ref;

	cmpctl_axil u_axil (
		.clk_i     (CORE_CLK_I),
		.rstn_i    (RSTN_I),
		.ce_i      (CE_I),
		.awaddr_i  (S_AXI_AWADDR_I),
		.awvalid_i (S_AXI_AWVALID_I),
		.awready_o (S_AXI_AWREADY_O),
		.wdata_i   (S_AXI_WDATA_I),
		.wstrb_i   (S_AXI_WSTRB_I),
		.wvalid_i  (S_AXI_WVALID_I),
		.wready_o  (S_AXI_WREADY_O),
		.bresp_o   (S_AXI_BRESP_O),
		.bvalid_o  (S_AXI_BVALID_O),
		.bready_i  (S_AXI_BREADY_I),
		.araddr_i  (S_AXI_ARADDR_I),
		.arvalid_i (S_AXI_ARVALID_I),
		.arready_o (S_AXI_ARREADY_O),
		.rdata_o   (S_AXI_RDATA_O),
		.rresp_o   (S_AXI_RRESP_O),
		.rvalid_o  (S_AXI_RVALID_O),
		.rready_i  (S_AXI_RREADY_I),
		.rif       (rif.bus)
	);

	// R4: mode field decodes routing and pin use
	always_comb
	begin
		cmp_on       = 1'b1;
		uses_ref     = 1'b0;
		drives_pin   = 1'b0;
		uses_pos_pin = 1'b0;
		case (mode_r)
			MODE_RESET, MODE_OFF:
				cmp_on = 1'b0;
			MODE_PIN_OUT:
			begin
				uses_pos_pin = 1'b1;
				drives_pin   = 1'b1;
			end
			MODE_PIN:
				uses_pos_pin = 1'b1;
			MODE_REF_OUT:
			begin
				uses_ref   = 1'b1;
				drives_pin = 1'b1;
			end
			MODE_REF, MODE_REF_SW:
				uses_ref = 1'b1;
			MODE_REF_SW_OUT:
			begin
				uses_ref   = 1'b1;
				drives_pin = 1'b1;
			end
			default:
				cmp_on = 1'b0;
		endcase
	end

	// R10: sixteen levels per range
	// R11: range bit one is the low range
	assign ref_code = ref_range_r
		? 7'(ref_level_r * REF_LOW_STEP)
		: 7'(REF_HIGH_BASE + ref_level_r * REF_HIGH_STEP);

	// R12: powered-down reference drives nothing
	assign REF_POWER_O = ref_enable_r;
	assign REF_CODE_O  = ref_enable_r ? CODE_W'(ref_code) : '0;
	// R13: sleep gates neither circuit, only the registers decide
	assign CMP_POWER_O = cmp_on;

	// R9: reference replaces the positive pin in four modes
	// R23: switch moves the negative input onto the positive pin
	always_comb
	begin
		positive_input = uses_ref ? REF_CODE_O : POS_PIN_CODE_I;
		negative_input = NEG_PIN_CODE_I;
		if ((mode_r == MODE_REF_SW || mode_r == MODE_REF_SW_OUT) && input_switch_r)
			negative_input = POS_PIN_CODE_I;
	end

	// R1: high only when positive strictly exceeds negative
	assign raw_result   = cmp_on && (positive_input > negative_input);
	// R2: invert bit complements the result
	assign shown_result = raw_result ^ output_invert_r;

	// R6: pin sees the unsynchronised result
	// R7: direction bit low enables the driver in output modes
	assign CMP_PIN_O    = drives_pin && shown_result;
	assign CMP_PIN_OE_O = drives_pin && !pin_direction_r[OUT_PIN];

	// R24: status and change logic see only the synchronised level
	cmpctl_sync u_sync (
		.clk_i  (CORE_CLK_I),
		.rstn_i (RSTN_I),
		.ce_i   (CE_I),
		.d_i    (shown_result),
		.q_o    (compare_result)
	);

	// R8: pins in analog use read as zero
	generate
		for (genvar p = 0; p < PIN_N; p++)
		begin : g_port
			always_comb
			begin
				if (p == NEG_PIN)
					analog_pin[p] = mode_r != MODE_OFF;
				else if (p == POS_PIN)
					analog_pin[p] = mode_r == MODE_RESET || uses_pos_pin ||
						mode_r == MODE_REF_SW || mode_r == MODE_REF_SW_OUT;
				else if (p == OUT_PIN)
					analog_pin[p] = mode_r == MODE_RESET;
				else
					analog_pin[p] = 1'b0;
			end
			assign port_data[p] = PIN_I[p] && !analog_pin[p];
		end
	endgenerate

	// register write decode
	assign wr_core  = rif.wr_stb && rif.wr_idx == IDX_CORE_IRQ;
	assign wr_flags = rif.wr_stb && rif.wr_idx == IDX_PERIPH_FLAGS;
	assign wr_cmp   = rif.wr_stb && rif.wr_idx == IDX_CMP_CTRL;
	assign wr_dir   = rif.wr_stb && rif.wr_idx == IDX_PIN_DIR;
	assign wr_en    = rif.wr_stb && rif.wr_idx == IDX_PERIPH_EN;
	assign wr_ref   = rif.wr_stb && rif.wr_idx == IDX_REF_CTRL;
	assign rif.wr_ok = cmpctl_is_mapped(rif.wr_idx);
	assign rif.rd_ok = cmpctl_is_mapped(rif.rd_idx);

	// R3: output status bit comes from hardware only
	// R22: unimplemented reference bits return zero
	always_comb
	begin
		rif.rd_data = '0;
		case (rif.rd_idx)
			IDX_CORE_IRQ:
				rif.rd_data = core_irq_r;
			IDX_PERIPH_FLAGS:
				rif.rd_data[CHANGE_BIT] = change_flag_r;
			IDX_CMP_CTRL:
			begin
				rif.rd_data[CMP_OUT_BIT]                   = compare_result;
				rif.rd_data[CMP_INV_BIT]                   = output_invert_r;
				rif.rd_data[CMP_SW_BIT]                    = input_switch_r;
				rif.rd_data[CMP_MODE_LSB +: MODE_W]        = mode_r;
			end
			IDX_PIN_DIR:
				rif.rd_data[PIN_N-1:0] = pin_direction_r;
			IDX_PERIPH_EN:
				rif.rd_data[CHANGE_BIT] = change_enable_r;
			IDX_REF_CTRL:
			begin
				rif.rd_data[REF_EN_BIT]            = ref_enable_r;
				rif.rd_data[REF_RANGE_BIT]         = ref_range_r;
				rif.rd_data[REF_LVL_LSB +: LVL_W]  = ref_level_r;
			end
			IDX_PORT_DATA:
				rif.rd_data[PIN_N-1:0] = port_data;
			default:
				rif.rd_data = '0;
		endcase
	end

	// R16: reset selects the reset mode
	// R15: only reset and control register writes touch these, so wake-up keeps them
	always_ff @(posedge CORE_CLK_I or negedge RSTN_I)
	begin
		if (!RSTN_I)
		begin
			output_invert_r <= RST_CMP_CTRL[CMP_INV_BIT];
			input_switch_r  <= RST_CMP_CTRL[CMP_SW_BIT];
			mode_r          <= RST_CMP_CTRL[CMP_MODE_LSB +: MODE_W];
		end
		else if (CE_I && wr_cmp)
		begin
			// R4: new mode takes effect on the write
			output_invert_r <= rif.wr_data[CMP_INV_BIT];
			input_switch_r  <= rif.wr_data[CMP_SW_BIT];
			mode_r          <= rif.wr_data[CMP_MODE_LSB +: MODE_W];
		end
	end

	// R16: reset switches the reference off
	always_ff @(posedge CORE_CLK_I or negedge RSTN_I)
	begin
		if (!RSTN_I)
		begin
			ref_enable_r <= RST_REF_CTRL[REF_EN_BIT];
			ref_range_r  <= RST_REF_CTRL[REF_RANGE_BIT];
			ref_level_r  <= RST_REF_CTRL[REF_LVL_LSB +: LVL_W];
		end
		else if (CE_I && wr_ref)
		begin
			ref_enable_r <= rif.wr_data[REF_EN_BIT];
			ref_range_r  <= rif.wr_data[REF_RANGE_BIT];
			ref_level_r  <= rif.wr_data[REF_LVL_LSB +: LVL_W];
		end
	end

	// enable and direction registers
	always_ff @(posedge CORE_CLK_I or negedge RSTN_I)
	begin
		if (!RSTN_I)
		begin
			core_irq_r      <= RST_CORE_IRQ;
			change_enable_r <= RST_PERIPH_EN[CHANGE_BIT];
			pin_direction_r <= RST_PIN_DIR[PIN_N-1:0];
		end
		else if (CE_I)
		begin
			if (wr_core)
				core_irq_r <= rif.wr_data;
			if (wr_en)
				change_enable_r <= rif.wr_data[CHANGE_BIT];
			if (wr_dir)
				pin_direction_r <= rif.wr_data[PIN_N-1:0];
		end
	end

	// R20: any access to the control register ends the mismatch
	assign ctl_access = (rif.rd_stb && rif.rd_idx == IDX_CMP_CTRL) || wr_cmp;
	assign mismatch   = compare_result != latched_out_r;

	always_ff @(posedge CORE_CLK_I or negedge RSTN_I)
	begin
		if (!RSTN_I)
			latched_out_r <= 1'b0;
		else if (CE_I && ctl_access)
			latched_out_r <= compare_result;
	end

	// R17: a standing mismatch keeps setting the flag
	// R21: a change landing on a control access is not flagged
	// R18: software writes either level; hardware set wins a clear
	always_comb
	begin
		change_flag_nxt = change_flag_r;
		if (wr_flags)
			change_flag_nxt = rif.wr_data[CHANGE_BIT];
		if (mismatch && !ctl_access)
			change_flag_nxt = 1'b1;
	end

	always_ff @(posedge CORE_CLK_I or negedge RSTN_I)
	begin
		if (!RSTN_I)
			change_flag_r <= RST_PERIPH_FLAGS[CHANGE_BIT];
		else if (CE_I)
			change_flag_r <= change_flag_nxt;
	end

	// R19: request needs change, peripheral and global enables
	assign IRQ_O  = change_flag_r && change_enable_r &&
		core_irq_r[PERIPH_EN_BIT] && core_irq_r[GLOBAL_EN_BIT];
	// R15: wake does not need the global enable, only a live comparator
	assign WAKE_O = SLEEP_I && cmp_on && change_flag_r && change_enable_r &&
		core_irq_r[PERIPH_EN_BIT];
endmodule // cmpctl_top

// File: include/cmpctl_pkg.sv
/*
 * Constants, register map and field layout of the comparator control block.
 * Assumes the register index is the byte address divided by four.
 */
package cmpctl_pkg;
	localparam int            AXI_ADDR_W       = 10;
	localparam int            AXI_DATA_W       = 32;
	localparam int            REG_W            = 8;
	localparam int            IDX_W            = 8;
	localparam int            PIN_N            = 6;
	localparam int            MODE_W           = 3;
	localparam int            LVL_W            = 4;
	// register indices; byte address is four times the index
	localparam logic [7:0]    IDX_CORE_IRQ     = 8'h0b;
	localparam logic [7:0]    IDX_PERIPH_FLAGS = 8'h0c;
	localparam logic [7:0]    IDX_CMP_CTRL     = 8'h19;
	localparam logic [7:0]    IDX_PIN_DIR      = 8'h85;
	localparam logic [7:0]    IDX_PERIPH_EN    = 8'h8c;
	localparam logic [7:0]    IDX_REF_CTRL     = 8'h99;
	localparam logic [7:0]    IDX_PORT_DATA    = 8'h05;
	// reset values
	localparam logic [7:0]    RST_CORE_IRQ     = 8'h00;
	localparam logic [7:0]    RST_PERIPH_FLAGS = 8'h00;
	localparam logic [7:0]    RST_CMP_CTRL     = 8'h00;
	localparam logic [7:0]    RST_PIN_DIR      = 8'h3f;
	localparam logic [7:0]    RST_PERIPH_EN    = 8'h00;
	localparam logic [7:0]    RST_REF_CTRL     = 8'h00;
	// field positions
	localparam int            CMP_OUT_BIT      = 6;
	localparam int            CMP_INV_BIT      = 4;
	localparam int            CMP_SW_BIT       = 3;
	localparam int            CMP_MODE_LSB     = 0;
	localparam int            REF_EN_BIT       = 7;
	localparam int            REF_RANGE_BIT    = 5;
	localparam int            REF_LVL_LSB      = 0;
	localparam int            CHANGE_BIT       = 3;
	localparam int            GLOBAL_EN_BIT    = 7;
	localparam int            PERIPH_EN_BIT    = 6;
	localparam int            NEG_PIN          = 0;
	localparam int            POS_PIN          = 1;
	localparam int            OUT_PIN          = 2;
	// reference in steps of a 96th of the supply: lcm of the two dividers
	localparam logic [6:0]    REF_FULL_SCALE   = 7'h60;
	localparam logic [6:0]    REF_LOW_STEP     = 7'h04;
	localparam logic [6:0]    REF_HIGH_BASE    = 7'h18;
	localparam logic [6:0]    REF_HIGH_STEP    = 7'h03;
	// mode field codes
	typedef logic [MODE_W-1:0] cmpctl_mode_t;
	localparam cmpctl_mode_t  MODE_RESET       = 3'h0;
	localparam cmpctl_mode_t  MODE_PIN_OUT     = 3'h1;
	localparam cmpctl_mode_t  MODE_PIN         = 3'h2;
	localparam cmpctl_mode_t  MODE_REF_OUT     = 3'h3;
	localparam cmpctl_mode_t  MODE_REF         = 3'h4;
	localparam cmpctl_mode_t  MODE_REF_SW      = 3'h5;
	localparam cmpctl_mode_t  MODE_REF_SW_OUT  = 3'h6;
	localparam cmpctl_mode_t  MODE_OFF         = 3'h7;
	localparam logic [1:0]    RESP_OKAY        = 2'h0;
	localparam logic [1:0]    RESP_SLVERR      = 2'h2;

	function automatic logic cmpctl_is_mapped(input logic [IDX_W-1:0] idx);
		return idx == IDX_CORE_IRQ || idx == IDX_PERIPH_FLAGS || idx == IDX_CMP_CTRL ||
			idx == IDX_PIN_DIR || idx == IDX_PERIPH_EN || idx == IDX_REF_CTRL ||
			idx == IDX_PORT_DATA;
	endfunction
endpackage

// File: include/cmpctl_reg_if.sv
/*
 * Register access strobes between the bus slave and the control core.
 * Assumes one clock; read data is combinational from the core.
 */
`timescale 1ns/1ps
interface cmpctl_reg_if;
	import cmpctl_pkg::*;
	logic             wr_stb;
	logic [IDX_W-1:0] wr_idx;
	logic [REG_W-1:0] wr_data;
	logic             wr_ok;
	logic             rd_stb;
	logic [IDX_W-1:0] rd_idx;
	logic [REG_W-1:0] rd_data;
	logic             rd_ok;

	modport bus  (output wr_stb, wr_idx, wr_data, rd_stb, rd_idx,
		input wr_ok, rd_data, rd_ok);
	modport core (input wr_stb, wr_idx, wr_data, rd_stb, rd_idx,
		output wr_ok, rd_data, rd_ok);
endinterface

// File: tb/cmpctl_analog_model.sv
/* Analog input pins and the output pin beside the comparator block.
 * Assumes the bench calls set_lvl just after a rising clock edge. */
`timescale 1ns/1ps
module cmpctl_analog_model (
	// output pin from the block
	input  wire logic pin_i,
	input  wire logic pin_oe_i,
	// levels into the block
	output logic [6:0] pos_o,
	output logic [6:0] neg_o,
	output logic [5:0] pins_o
);
	// undriven pin shows the opposite level, so a stale read is caught
	assign pins_o = {3'h7, pin_oe_i ? pin_i : ~pin_i, 2'h3};
	initial
	begin
		pos_o = 7'h00;
		neg_o = 7'h00;
	end
	task automatic set_lvl(input logic [6:0] p, input logic [6:0] n);
		pos_o <= p;
		neg_o <= n;
	endtask
endmodule // cmpctl_analog_model

// File: tb/cmpctl_sva.sv
/* Checker for cmpctl_top, watching its ports only.
 * Assumes it is attached by the bind at the foot of this file. */
`timescale 1ns/1ps
module cmpctl_sva #(
	parameter int CODE_W = 7
) (
	// clock and reset
	input wire logic              CORE_CLK_I,
	input wire logic              RSTN_I,
	// read address and answer
	input wire logic              S_AXI_ARVALID_I,
	input wire logic              S_AXI_ARREADY_O,
	input wire logic              S_AXI_RVALID_O,
	// analog and pin side
	input wire logic [CODE_W-1:0] REF_CODE_O,
	input wire logic              REF_POWER_O,
	input wire logic              CMP_POWER_O,
	input wire logic              CMP_PIN_O,
	input wire logic              CMP_PIN_OE_O,
	input wire logic              SLEEP_I,
	input wire logic              WAKE_O
);
	default clocking @(posedge CORE_CLK_I); endclocking
	default disable iff (!RSTN_I);
	sequence s_ar_taken;
		S_AXI_ARVALID_I && S_AXI_ARREADY_O;
	endsequence
	a_read_answer: assert property (s_ar_taken |=> S_AXI_RVALID_O)
		else $error("read answer late");
	a_oe_needs_power: assert property (CMP_PIN_OE_O |-> CMP_POWER_O)
		else $error("pin driven while comparator off");
	a_pin_idle_low: assert property (!CMP_POWER_O |-> !CMP_PIN_O)
		else $error("pin level while comparator off");
	a_ref_off_zero: assert property (!REF_POWER_O |-> REF_CODE_O == 0)
		else $error("reference level while powered down");
	a_ref_in_range: assert property (REF_CODE_O <= 7'h45)
		else $error("reference level out of range");
	a_wake_in_sleep: assert property (WAKE_O |-> SLEEP_I && CMP_POWER_O)
		else $error("wake without sleeping comparator");
	a_reset_state: assert property ($rose(RSTN_I) |-> !CMP_POWER_O && !REF_POWER_O)
		else $error("circuits on after reset");
	a_sleep_keeps_on: assert property ($rose(SLEEP_I) |->
		CMP_POWER_O == $past(CMP_POWER_O) && REF_POWER_O == $past(REF_POWER_O))
		else $error("sleep changed circuit power");
endmodule // cmpctl_sva

bind cmpctl_top cmpctl_sva #(.CODE_W(CODE_W)) u_sva (
	.CORE_CLK_I(CORE_CLK_I), .RSTN_I(RSTN_I), .S_AXI_ARVALID_I(S_AXI_ARVALID_I),
	.S_AXI_ARREADY_O(S_AXI_ARREADY_O), .S_AXI_RVALID_O(S_AXI_RVALID_O),
	.REF_CODE_O(REF_CODE_O), .REF_POWER_O(REF_POWER_O), .CMP_POWER_O(CMP_POWER_O),
	.CMP_PIN_O(CMP_PIN_O), .CMP_PIN_OE_O(CMP_PIN_OE_O), .SLEEP_I(SLEEP_I),
	.WAKE_O(WAKE_O));

// File: tb/cmpctl_top_tb.sv
/* Self-checking bench for cmpctl_top, registers over AXI4-Lite.
 * Assumes the analog partner model and the bound checker. */
`timescale 1ns/1ps
module cmpctl_top_tb;
	import cmpctl_pkg::*;
	logic        clk = 1'h0, rstn = 1'h0, slp = 1'h0;
	logic [9:0]  awa = '0, ara = '0;
	logic [31:0] wd = '0, rdt, d;
	logic        awv = 0, wv = 0, br = 0, arv = 0, rr = 0;
	logic        awr, wr_, bv, arr, rv, refp, cmpp, pin, oe, irq, wake;
	logic [1:0]  bres, rres, r;
	logic [6:0]  pos, neg, refc;
	logic [5:0]  pins;
	int          miscompares = 0, checks = 0, cyc = 0;
	logic [7:0]  ix [6] = '{IDX_CORE_IRQ, IDX_PERIPH_FLAGS, IDX_CMP_CTRL,
		IDX_PIN_DIR, IDX_PERIPH_EN, IDX_REF_CTRL};
	logic [7:0]  rv_ [6] = '{RST_CORE_IRQ, RST_PERIPH_FLAGS, RST_CMP_CTRL,
		RST_PIN_DIR, RST_PERIPH_EN, RST_REF_CTRL};
	always #20 clk = ~clk;
	cmpctl_top dut (.CORE_CLK_I(clk), .RSTN_I(rstn), .CE_I(1'h1),
		.S_AXI_AWADDR_I(awa), .S_AXI_AWVALID_I(awv), .S_AXI_AWREADY_O(awr),
		.S_AXI_WDATA_I(wd), .S_AXI_WSTRB_I(4'hf), .S_AXI_WVALID_I(wv),
		.S_AXI_WREADY_O(wr_), .S_AXI_BRESP_O(bres), .S_AXI_BVALID_O(bv),
		.S_AXI_BREADY_I(br), .S_AXI_ARADDR_I(ara), .S_AXI_ARVALID_I(arv),
		.S_AXI_ARREADY_O(arr), .S_AXI_RDATA_O(rdt), .S_AXI_RRESP_O(rres),
		.S_AXI_RVALID_O(rv), .S_AXI_RREADY_I(rr), .POS_PIN_CODE_I(pos),
		.NEG_PIN_CODE_I(neg), .REF_CODE_O(refc), .REF_POWER_O(refp),
		.CMP_POWER_O(cmpp), .PIN_I(pins), .CMP_PIN_O(pin), .CMP_PIN_OE_O(oe),
		.SLEEP_I(slp), .IRQ_O(irq), .WAKE_O(wake));
	cmpctl_analog_model u_ana (.pin_i(pin), .pin_oe_i(oe), .pos_o(pos),
		.neg_o(neg), .pins_o(pins));
	task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
		checks++;
		if (g !== e)
		begin
			miscompares++;
			$display("unexpected %s: expected %h seen %h", n, e, g);
		end
	endtask
	task automatic wr(input logic [7:0] i, input logic [7:0] v);
		awa <= {i, 2'h0};
		wd <= {24'h0, v};
		awv <= 1'h1;
		wv <= 1'h1;
		br <= 1'h1;
		do
		begin
			@(posedge clk);
			if (awr) awv <= 1'h0;
			if (wr_) wv <= 1'h0;
		end while (!bv);
		r = bres;
		br <= 1'h0;
		@(posedge clk);
	endtask
	task automatic rd(input logic [7:0] i);
		ara <= {i, 2'h0};
		arv <= 1'h1;
		rr <= 1'h1;
		do
		begin
			@(posedge clk);
			if (arr) arv <= 1'h0;
		end while (!rv);
		d = rdt;
		r = rres;
		rr <= 1'h0;
		@(posedge clk);
	endtask
	task automatic rchk(input logic [7:0] i, input logic [7:0] e);
		rd(i);
		chk("read data", {24'h0, e}, d);
		chk("read resp", RESP_OKAY, r);
	endtask
	// two-stage sync plus margin before the status is looked at
	task automatic settle;
		repeat (4) @(posedge clk);
	endtask
	task automatic stop_test;
		$display("checks %0d miscompares %0d", checks, miscompares);
		if (miscompares == 0 && checks > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask
	always @(posedge clk)
	begin
		cyc <= cyc + 1;
		if (cyc == 20000)
		begin
			miscompares++;
			stop_test;
		end
	end
	initial
	begin
		repeat (20) @(posedge clk);
		rstn <= 1'h1;
		@(posedge clk);
		foreach (ix[k]) rchk(ix[k], rv_[k]);
		rd(8'hff);
		chk("unmapped resp", RESP_SLVERR, r);
		wr(8'hff, 8'h55);
		chk("unmapped resp", RESP_SLVERR, r);
		u_ana.set_lvl(7'h00, 7'h50);
		for (int m = 0; m < 8; m++)
		begin
			wr(IDX_CMP_CTRL, 8'(m));
			rchk(IDX_CMP_CTRL, 8'(m));
			chk("cmp power", m != 0 && m != 7, cmpp);
		end
		u_ana.set_lvl(7'h20, 7'h40);
		wr(IDX_CMP_CTRL, 8'h42);
		settle;
		rchk(IDX_CMP_CTRL, 8'h02);
		wr(IDX_CMP_CTRL, 8'h12);
		rchk(IDX_CMP_CTRL, 8'h52);
		u_ana.set_lvl(7'h40, 7'h20);
		settle;
		rchk(IDX_CMP_CTRL, 8'h12);
		wr(IDX_CMP_CTRL, 8'h02);
		rchk(IDX_CMP_CTRL, 8'h42);
		for (int k = 0; k < 32; k++)
		begin
			wr(IDX_REF_CTRL, {2'h2, k[4], 1'h0, k[3:0]});
			chk("ref code", k[4] ? 4 * k[3:0] : 24 + 3 * k[3:0], refc);
		end
		wr(IDX_REF_CTRL, 8'hff);
		rchk(IDX_REF_CTRL, 8'haf);
		wr(IDX_REF_CTRL, 8'h2f);
		chk("ref power", 0, refp);
		wr(IDX_REF_CTRL, 8'ha6);
		u_ana.set_lvl(7'h30, 7'h10);
		wr(IDX_CMP_CTRL, 8'h04);
		settle;
		rchk(IDX_CMP_CTRL, 8'h44);
		wr(IDX_CMP_CTRL, 8'h0d);
		settle;
		rchk(IDX_CMP_CTRL, 8'h0d);
		wr(IDX_CMP_CTRL, 8'h05);
		settle;
		rchk(IDX_CMP_CTRL, 8'h45);
		u_ana.set_lvl(7'h10, 7'h30);
		wr(IDX_CMP_CTRL, 8'h01);
		chk("pin enable", 0, oe);
		wr(IDX_PIN_DIR, 8'h3b);
		chk("pin enable", 1, oe);
		chk("pin level", 0, pin);
		u_ana.set_lvl(7'h30, 7'h10);
		@(posedge clk);
		chk("pin level", 1, pin);
		wr(IDX_CMP_CTRL, 8'h13);
		chk("pin level", 0, pin);
		wr(IDX_CMP_CTRL, 8'h1e);
		chk("pin level", 1, pin);
		chk("pin enable", 1, oe);
		wr(IDX_CMP_CTRL, 8'h07);
		chk("pin enable", 0, oe);
		rchk(IDX_PORT_DATA, 8'h3f);
		wr(IDX_CMP_CTRL, 8'h00);
		rchk(IDX_PORT_DATA, 8'h38);
		u_ana.set_lvl(7'h10, 7'h30);
		wr(IDX_CMP_CTRL, 8'h02);
		settle;
		rchk(IDX_CMP_CTRL, 8'h02);
		wr(IDX_PERIPH_FLAGS, 8'h00);
		rchk(IDX_PERIPH_FLAGS, 8'h00);
		wr(IDX_PERIPH_EN, 8'h08);
		wr(IDX_CORE_IRQ, 8'hc0);
		u_ana.set_lvl(7'h30, 7'h10);
		rchk(IDX_CMP_CTRL, 8'h02);
		settle;
		rchk(IDX_PERIPH_FLAGS, 8'h08);
		chk("irq", 1, irq);
		wr(IDX_CORE_IRQ, 8'h40);
		chk("irq", 0, irq);
		wr(IDX_PERIPH_FLAGS, 8'h00);
		settle;
		rchk(IDX_PERIPH_FLAGS, 8'h08);
		rchk(IDX_CMP_CTRL, 8'h42);
		wr(IDX_PERIPH_FLAGS, 8'h00);
		rchk(IDX_PERIPH_FLAGS, 8'h00);
		wr(IDX_PERIPH_FLAGS, 8'h08);
		rchk(IDX_PERIPH_FLAGS, 8'h08);
		slp <= 1'h1;
		@(posedge clk);
		chk("wake", 1, wake);
		chk("ref power", 1, refp);
		rchk(IDX_CMP_CTRL, 8'h42);
		wr(IDX_CMP_CTRL, 8'h07);
		wr(IDX_REF_CTRL, 8'h00);
		chk("cmp power", 0, cmpp);
		chk("wake", 0, wake);
		stop_test;
	end
endmodule // cmpctl_top_tb
